// >>> logic/efd_decoder.sv
// Operand specifier decoder: walks the bytes of one operand field, picks
// register banks, forms the effective address and flags faulting codes.
// Assumes fetch offers big-endian bytes synchronous to i_clk and a register
// file that answers one cycle after its read address settles.
//
// Summary of operation
// - Code 1111101 with first byte top bit 0 is PC-relative with index.
// - Code 1111101 with first byte starting 10 is plain PC-relative.
// - Code 1111110 is double indirect; sizes only 01 or 11, else illegal.
// - Code 1111111 and unused expansion patterns, such as 1111100 with first byte top bit 1, raise illegal instruction.
// - Code 1110000 is a current-bank prefix before an ordinary operand code.
// - Code 1110100 is a previous-bank prefix using current bank minus one.
// - Without prefix, base and index registers come from the global bank.
// - Bank prefixes only in ring mode; in global mode raise bank exception.
// - Prefixed base uses prefix bank; register-index index stays global, PC-index follows prefix.
// - Chained prefixes: only the last one counts.
// - Prefixed fields still take bit 7 as the accumulator bit.
// - Register indirect address is base plus sign-extended 0, 8, 16 or 32-bit displacement.
// - Accumulator bit set in two-operand instruction forces R0 destination, no destination field.
`timescale 1ns/1ns
module efd_decoder
  import efd_pkg::*;
#(
  parameter int BANK_W = 4
) (
  // Clock and reset
  input logic i_clk,
  input logic i_rst,
  // Instruction byte stream
  input logic i_byte_valid,
  input logic [7:0] i_byte,
  input logic i_two_operand,
  input logic [31:0] i_pc,
  output logic o_byte_ready,
  // Bank state
  input logic i_ring_mode,
  input logic [BANK_W-1:0] i_global_bank_number,
  input logic [BANK_W-1:0] i_current_bank_number,
  // Register file read
  output logic [BANK_W-1:0] o_base_bank,
  output logic [3:0] o_base_select,
  output logic [BANK_W-1:0] o_index_bank,
  output logic [3:0] o_index_select,
  input logic [31:0] i_base_data,
  input logic [31:0] i_index_data,
  // Decode results
  output logic o_done,
  output efd_mode_t o_mode,
  output logic [31:0] o_effective_address,
  output logic [31:0] o_outer_displacement,
  output logic [3:0] o_exp_bytes,
  output logic o_acc_dest,
  output logic o_expect_dest,
  output logic o_side_effect_en,
  output logic o_illegal_exc,
  output logic o_bank_exc,
  // Register port and interrupt
  input logic [1:0] i_reg_addr,
  input logic [31:0] i_reg_wdata,
  input logic i_reg_wr,
  input logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  output logic o_irq
);

  if (BANK_W < 1 || BANK_W > 8) begin : g_check
    $error("BANK_W must lie between 1 and 8");
  end

  // Bank number for a prefix selection
  function automatic logic [BANK_W-1:0] bank_of(input efd_bank_t sel, input logic [BANK_W-1:0] g,
                                                 input logic [BANK_W-1:0] c);
    unique case (sel)
      BANK_GLOBAL: bank_of = g;
      BANK_CURRENT: bank_of = c;
      BANK_PREVIOUS: bank_of = BANK_W'(c - 1'b1);
      default: bank_of = g;
    endcase
  endfunction

  efd_state_t state_reg, state_next;
  efd_mode_t mode_reg, mode_next;
  efd_bank_t bank_sel_reg;
  logic ready_reg;
  logic prefix_seen_reg;
  logic acc_reg, two_op_reg;
  logic [1:0] size_reg, size_next;
  logic [1:0] outer_size_reg;
  logic [1:0] scale_reg;
  logic long_index_reg;
  logic outer_phase_reg;
  logic [3:0] left_reg;
  logic [3:0] exp_total_reg;
  logic [6:0] code_reg;
  logic [31:0] disp_reg, outer_reg;
  logic [EVT_W-1:0] status_reg, mask_reg;

  // Byte handshake and field decode
  wire byte_fire = i_byte_valid & ready_reg;
  assign o_byte_ready = ready_reg;
  wire [6:0] code = i_byte[6:0];
  wire in_code = byte_fire && state_reg == ST_CODE;
  wire in_ext1 = byte_fire && state_reg == ST_EXT1;
  wire in_ext2 = byte_fire && state_reg == ST_EXT2;
  wire in_disp = byte_fire && state_reg == ST_DISP;
  wire is_prefix = code == CODE_CUR_BANK || code == CODE_PREV_BANK;
  wire [1:0] ext_size = i_byte[5:4];
  wire [1:0] inner_size = i_byte[7:6];
  wire [3:0] size_bytes = disp_bytes(size_next);
  wire last_disp = left_reg == 4'h1;

  wire bank_fault = in_code && is_prefix && !i_ring_mode;
  wire code_illegal = in_code && code == CODE_UNUSED;
  wire ext_illegal_idx = code_reg == CODE_INDEXED && i_byte[7];
  wire ext_illegal_pc = code_reg == CODE_PC && i_byte[7] && i_byte[6];
  wire ext_illegal_dbl = code_reg == CODE_DOUBLE && !(inner_size[0] && ext_size[0]);
  wire ext_illegal = in_ext1 && (ext_illegal_idx || ext_illegal_pc || ext_illegal_dbl);
  wire illegal_fault = code_illegal || ext_illegal;
  wire any_fault = illegal_fault || bank_fault;

  // Address arithmetic
  wire pc_based = mode_reg == MODE_PC_REL || mode_reg == MODE_PC_INDEX;
  wire no_base = mode_reg == MODE_IMM || mode_reg == MODE_ABS || mode_reg == MODE_REG_DIRECT;
  wire indexed = mode_reg == MODE_REG_INDEX || mode_reg == MODE_PC_INDEX;
  wire [31:0] disp_ext = sext_disp(disp_reg, size_reg);
  wire [31:0] outer_ext = sext_disp(outer_reg, outer_size_reg);
  wire [31:0] index_ext = long_index_reg ? i_index_data : {{16{i_index_data[15]}}, i_index_data[15:0]};
  wire [31:0] index_term = indexed ? index_ext << scale_reg : ZERO_WORD;
  wire [31:0] base_raw = pc_based ? i_pc : (no_base ? ZERO_WORD : i_base_data);
  wire [31:0] base_term = mode_reg == MODE_SCALE ? base_raw << scale_reg : base_raw;
  wire [31:0] ea_value = base_term + disp_ext + index_term;
  wire [BANK_W-1:0] prefix_bank = bank_of(prefix_seen_reg ? bank_sel_reg : BANK_GLOBAL,
                                          i_global_bank_number, i_current_bank_number);

  // Events and register port
  wire [EVT_W-1:0] events = {state_reg == ST_CALC, bank_fault, illegal_fault};
  wire rd_status = i_reg_rd && i_reg_addr == REG_STATUS;
  wire wr_mask = i_reg_wr && i_reg_addr == REG_MASK;
  wire [EVT_W-1:0] status_next = (status_reg & ~{EVT_W{rd_status}}) | events;
  wire [EVT_W-1:0] mask_next = wr_mask ? i_reg_wdata[EVT_W-1:0] : mask_reg;
  wire [31:0] rd_mux = i_reg_addr == REG_STATUS ? 32'(status_reg) :
                       i_reg_addr == REG_MASK ? 32'(mask_reg) :
                       i_reg_addr == REG_STATE ? 32'({prefix_seen_reg, bank_sel_reg, state_reg}) : ZERO_WORD;

  // Mode, size and next state
  always_comb begin
    mode_next = mode_reg;
    size_next = size_reg;
    state_next = state_reg;
    unique case (state_reg)
      ST_CODE: begin
        if (in_code && !is_prefix && !code_illegal) begin
          size_next = code[1:0];
          state_next = ST_DISP;
          if (!code[6]) begin
            mode_next = MODE_REG_IND;
            size_next = code[5:4];
            state_next = code[5:4] == SZ_NONE ? ST_READ : ST_DISP;
          end else begin
            unique case (code[5:4])
              2'h0: mode_next = MODE_REG_DIRECT;
              2'h1: mode_next = MODE_AUTO_INC;
              2'h2: mode_next = MODE_AUTO_DEC;
              2'h3: mode_next = !code[3] ? (code[2] ? MODE_ABS : MODE_IMM) :
                                (!code[2] ? MODE_SCALE : MODE_REG_INDEX);
            endcase
            if (code[5:4] != 2'h3) begin
              state_next = ST_READ;
            end else if (code[3]) begin
              state_next = ST_EXT1;
            end
          end
        end
      end
      ST_EXT1: begin
        if (in_ext1) begin
          state_next = ST_EXT2;
          if (mode_reg == MODE_SCALE) begin
            state_next = size_reg == SZ_NONE ? ST_READ : ST_DISP;
          end else if (code_reg == CODE_DOUBLE) begin
            mode_next = MODE_DOUBLE;
            size_next = inner_size;
            state_next = ST_DISP;
          end else if (code_reg == CODE_PC && !i_byte[7]) begin
            mode_next = MODE_PC_INDEX;
            size_next = ext_size;
          end else if (code_reg == CODE_PC) begin
            mode_next = MODE_PC_REL;
            size_next = ext_size;
            state_next = ext_size == SZ_NONE ? ST_READ : ST_DISP;
          end else begin
            size_next = ext_size;
          end
          if (ext_illegal) begin
            state_next = ST_CODE;
          end
        end
      end
      ST_EXT2: begin
        if (in_ext2) begin
          state_next = size_reg == SZ_NONE ? ST_READ : ST_DISP;
        end
      end
      ST_DISP: begin
        if (in_disp && last_disp && !(mode_reg == MODE_DOUBLE && !outer_phase_reg)) begin
          state_next = ST_READ;
        end
      end
      ST_READ: state_next = ST_CALC;
      ST_CALC: state_next = ST_CODE;
    endcase
  end

  // Sequencer and operand fields
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ST_CODE;
      ready_reg <= 1'b0;
      mode_reg <= MODE_REG_DIRECT;
      size_reg <= SZ_NONE;
      code_reg <= 7'h00;
      left_reg <= EXP_RESET;
      outer_phase_reg <= 1'b0;
      outer_size_reg <= SZ_NONE;
    end else begin
      state_reg <= state_next;
      ready_reg <= state_next != ST_READ && state_next != ST_CALC;
      mode_reg <= mode_next;
      size_reg <= size_next;
      if (in_code) begin
        code_reg <= code;
        outer_phase_reg <= 1'b0;
      end
      if (in_ext1 && code_reg == CODE_DOUBLE) begin
        outer_size_reg <= ext_size;
      end
      if (state_next == ST_DISP && state_reg != ST_DISP) begin
        left_reg <= size_bytes;
      end else if (in_disp && last_disp) begin
        outer_phase_reg <= 1'b1;
        left_reg <= disp_bytes(outer_size_reg);
      end else if (in_disp) begin
        left_reg <= left_reg - 4'h1;
      end
    end
  end

  // Prefixes, register selects and displacement bytes
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bank_sel_reg <= BANK_GLOBAL;
      prefix_seen_reg <= 1'b0;
      acc_reg <= 1'b0;
      two_op_reg <= 1'b0;
      o_base_bank <= '0;
      o_base_select <= 4'h0;
      o_index_bank <= '0;
      o_index_select <= 4'h0;
      scale_reg <= 2'h0;
      long_index_reg <= 1'b0;
      disp_reg <= ZERO_WORD;
      outer_reg <= ZERO_WORD;
      exp_total_reg <= EXP_RESET;
    end else begin
      if (in_code && !prefix_seen_reg) begin
        // Accumulator bit from first field byte
        acc_reg <= i_byte[7];
        two_op_reg <= i_two_operand;
      end
      if (in_code && is_prefix && i_ring_mode) begin
        bank_sel_reg <= code == CODE_CUR_BANK ? BANK_CURRENT : BANK_PREVIOUS;
        prefix_seen_reg <= 1'b1;
      end else if (any_fault || state_reg == ST_CALC) begin
        bank_sel_reg <= BANK_GLOBAL;
        prefix_seen_reg <= 1'b0;
      end
      if (in_code && !is_prefix) begin
        o_base_bank <= prefix_bank;
        o_base_select <= code[3:0];
        disp_reg <= ZERO_WORD;
        outer_reg <= ZERO_WORD;
        scale_reg <= 2'h0;
        // Bytes implied by the code alone
        exp_total_reg <= code[6] && code[5:4] == 2'h3 && code[3] ? ONE_EXT_BYTE :
                         (state_next == ST_DISP ? size_bytes : EXP_RESET);
      end
      if (in_ext1) begin
        long_index_reg <= i_byte[6];
        if (mode_reg == MODE_SCALE) begin
          scale_reg <= i_byte[5:4];
          o_base_select <= i_byte[3:0];
          exp_total_reg <= ONE_EXT_BYTE + disp_bytes(size_reg);
        end else if (code_reg == CODE_DOUBLE) begin
          o_base_select <= i_byte[3:0];
          exp_total_reg <= ONE_EXT_BYTE + disp_bytes(inner_size) + disp_bytes(ext_size);
        end else if (state_next == ST_EXT2) begin
          o_base_select <= i_byte[3:0];
          exp_total_reg <= TWO_EXT_BYTES + size_bytes;
        end else begin
          exp_total_reg <= ONE_EXT_BYTE + size_bytes;
        end
      end
      if (in_ext2) begin
        scale_reg <= i_byte[5:4];
        o_index_select <= i_byte[3:0];
        o_index_bank <= mode_reg == MODE_PC_INDEX ? prefix_bank : i_global_bank_number;
      end
      if (in_disp && outer_phase_reg) begin
        outer_reg <= {outer_reg[23:0], i_byte};
      end else if (in_disp) begin
        disp_reg <= {disp_reg[23:0], i_byte};
      end
    end
  end

  // Results and exceptions
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_done <= 1'b0;
      o_mode <= MODE_REG_DIRECT;
      o_effective_address <= ZERO_WORD;
      o_outer_displacement <= ZERO_WORD;
      o_exp_bytes <= EXP_RESET;
      o_acc_dest <= 1'b0;
      o_expect_dest <= 1'b0;
      o_side_effect_en <= 1'b0;
      o_illegal_exc <= 1'b0;
      o_bank_exc <= 1'b0;
    end else begin
      o_done <= state_reg == ST_CALC;
      o_illegal_exc <= illegal_fault;
      o_bank_exc <= bank_fault;
      o_side_effect_en <= state_reg == ST_CALC && (mode_reg == MODE_AUTO_INC || mode_reg == MODE_AUTO_DEC);
      if (state_reg == ST_CALC) begin
        o_mode <= mode_reg;
        o_effective_address <= ea_value;
        o_outer_displacement <= outer_ext;
        o_exp_bytes <= exp_total_reg;
        o_acc_dest <= acc_reg && two_op_reg;
        o_expect_dest <= two_op_reg && !acc_reg;
      end
    end
  end

  // Status, mask, read data and interrupt
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      status_reg <= STATUS_RESET;
      mask_reg <= MASK_RESET;
      o_reg_rdata <= ZERO_WORD;
      o_irq <= 1'b0;
    end else begin
      status_reg <= status_next;
      mask_reg <= mask_next;
      o_reg_rdata <= i_reg_rd ? rd_mux : ZERO_WORD;
      o_irq <= |(status_next & mask_next);
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  pc_index_sel_a: assert property (in_ext1 && code_reg == CODE_PC && !i_byte[7]
    |=> mode_reg == MODE_PC_INDEX && state_reg == ST_EXT2) else $error("PC index mode not chosen");
  pc_rel_sel_a: assert property (in_ext1 && code_reg == CODE_PC && i_byte[7:6] == 2'h2
    |=> mode_reg == MODE_PC_REL && !o_illegal_exc) else $error("PC relative mode not chosen");
  double_size_a: assert property (in_ext1 && code_reg == CODE_DOUBLE && !i_byte[4]
    |=> o_illegal_exc && state_reg == ST_CODE) else $error("Bad double size accepted");
  unused_code_a: assert property (in_code && (code == CODE_UNUSED)
    |=> o_illegal_exc && !o_bank_exc) else $error("Unused code not trapped");
  prev_bank_a: assert property (in_code && !is_prefix && prefix_seen_reg && bank_sel_reg == BANK_PREVIOUS
    |=> o_base_bank == BANK_W'($past(i_current_bank_number) - 1'b1)) else $error("Previous bank wrong");
  global_bank_a: assert property (in_code && !is_prefix && !prefix_seen_reg && !code_illegal
    |=> o_base_bank == $past(i_global_bank_number)) else $error("Global bank not used");
  ring_only_a: assert property (in_code && is_prefix && !i_ring_mode
    |=> o_bank_exc && !prefix_seen_reg) else $error("Prefix accepted outside ring mode");
  last_prefix_a: assert property (in_code && code == CODE_CUR_BANK && i_ring_mode
    |=> bank_sel_reg == BANK_CURRENT ##0 prefix_seen_reg) else $error("Latest prefix not kept");
  reg_ind_ea_a: assert property (state_reg == ST_CALC && mode_reg == MODE_REG_IND
    |=> o_done && o_effective_address == $past(i_base_data) + $past(disp_ext)) else $error("Bad indirect address");
  fault_quiet_a: assert property (o_illegal_exc || o_bank_exc
    |-> !o_side_effect_en && !o_done) else $error("Side effect on faulting operand");

endmodule

// >>> logic/efd_pkg.sv
// Shared constants, types and helpers for the operand specifier decoder.
// Assumes one core clock; imported whole by the decoder module.
package efd_pkg;

  // Special operand codes
  localparam logic [6:0] CODE_CUR_BANK = 7'h70;
  localparam logic [6:0] CODE_PREV_BANK = 7'h74;
  localparam logic [6:0] CODE_INDEXED = 7'h7C;
  localparam logic [6:0] CODE_PC = 7'h7D;
  localparam logic [6:0] CODE_DOUBLE = 7'h7E;
  localparam logic [6:0] CODE_UNUSED = 7'h7F;

  // Size field encodings
  localparam logic [1:0] SZ_NONE = 2'h0;
  localparam logic [1:0] SZ_8 = 2'h1;
  localparam logic [1:0] SZ_16 = 2'h2;
  localparam logic [1:0] SZ_32 = 2'h3;

  // Register port map (word index)
  localparam logic [1:0] REG_STATUS = 2'h0;
  localparam logic [1:0] REG_MASK = 2'h1;
  localparam logic [1:0] REG_STATE = 2'h2;

  // Event bits of status and mask
  localparam int EVT_W = 3;
  localparam int EVT_ILLEGAL = 0;
  localparam int EVT_BANK = 1;
  localparam int EVT_DONE = 2;
  localparam logic [EVT_W-1:0] STATUS_RESET = 3'h0;
  localparam logic [EVT_W-1:0] MASK_RESET = 3'h0;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [3:0] EXP_RESET = 4'h0;
  localparam logic [3:0] ONE_EXT_BYTE = 4'h1;
  localparam logic [3:0] TWO_EXT_BYTES = 4'h2;

  typedef enum logic [1:0] {BANK_GLOBAL, BANK_CURRENT, BANK_PREVIOUS} efd_bank_t;

  typedef enum logic [3:0] {
    MODE_REG_DIRECT, MODE_REG_IND, MODE_AUTO_INC, MODE_AUTO_DEC, MODE_IMM, MODE_ABS,
    MODE_SCALE, MODE_REG_INDEX, MODE_PC_INDEX, MODE_PC_REL, MODE_DOUBLE
  } efd_mode_t;

  typedef enum logic [2:0] {ST_CODE, ST_EXT1, ST_EXT2, ST_DISP, ST_READ, ST_CALC} efd_state_t;

  // Expansion bytes carried by a size field
  function automatic logic [3:0] disp_bytes(input logic [1:0] sz);
    unique case (sz)
      SZ_NONE: disp_bytes = 4'h0;
      SZ_8: disp_bytes = 4'h1;
      SZ_16: disp_bytes = 4'h2;
      SZ_32: disp_bytes = 4'h4;
    endcase
  endfunction

  // Sign extension of a gathered displacement
  function automatic logic [31:0] sext_disp(input logic [31:0] raw, input logic [1:0] sz);
    unique case (sz)
      SZ_NONE: sext_disp = ZERO_WORD;
      SZ_8: sext_disp = {{24{raw[7]}}, raw[7:0]};
      SZ_16: sext_disp = {{16{raw[15]}}, raw[15:0]};
      SZ_32: sext_disp = raw;
    endcase
  endfunction

endpackage

// >>> tb/efd_regfile_model.sv
// Register file model answering the decoder's base and index reads.
// Assumes read data may lag the register selects by one core clock.
`timescale 1ns/1ns
module efd_regfile_model #(
  parameter int BANK_W = 4
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Selects from the decoder
  input wire logic [BANK_W-1:0] i_base_bank,
  input wire logic [3:0] i_base_select,
  input wire logic [BANK_W-1:0] i_index_bank,
  input wire logic [3:0] i_index_select,
  // Register contents
  output logic [31:0] o_base_data,
  output logic [31:0] o_index_data
);
  // Contents carry bank and number so a wrong select shows
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_base_data <= 32'h5555_AAAA;
      o_index_data <= 32'hAAAA_5555;
    end else begin
      o_base_data <= {8'(i_base_bank), 4'h0, i_base_select, 16'h7A3C};
      o_index_data <= {8'(i_index_bank), 4'h0, i_index_select, 16'h8F11};
    end
  end
endmodule

// >>> tb/efd_decoder_tb_top.sv
// Testbench for the operand decoder: drives fetch bytes, bank state and
// the register port. Assumes efd_pkg and the register file model.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("FAIL %s expected %h seen %h", nm, e, g); end end
module efd_decoder_tb_top;
  import efd_pkg::*;
  localparam logic [31:0] DV = 32'h8765_4381;
  localparam logic [31:0] DW = 32'h1234_56F0;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_byte_valid = 1'b0;
  logic [7:0] i_byte = 8'h00;
  logic i_two_operand = 1'b0;
  logic [31:0] i_pc = 32'h0004_1F00;
  logic i_ring_mode = 1'b1;
  logic [3:0] i_global_bank_number = 4'h9;
  logic [3:0] i_current_bank_number = 4'h6;
  logic [1:0] i_reg_addr = 2'h0;
  logic [31:0] i_reg_wdata = 32'h0000_0000;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [31:0] i_base_data, i_index_data, o_effective_address, o_outer_displacement, o_reg_rdata;
  logic [3:0] o_base_bank, o_base_select, o_index_bank, o_index_select, o_exp_bytes;
  logic o_byte_ready, o_done, o_acc_dest, o_expect_dest, o_side_effect_en, o_illegal_exc, o_bank_exc, o_irq;
  efd_mode_t o_mode;
  logic sd, si, sb, sse;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  int n, m;

  efd_decoder efd_decoder_inst (.i_clk, .i_rst, .i_byte_valid, .i_byte, .i_two_operand, .i_pc, .o_byte_ready,
    .i_ring_mode, .i_global_bank_number, .i_current_bank_number, .o_base_bank, .o_base_select, .o_index_bank,
    .o_index_select, .i_base_data, .i_index_data, .o_done, .o_mode, .o_effective_address, .o_outer_displacement,
    .o_exp_bytes, .o_acc_dest, .o_expect_dest, .o_side_effect_en, .o_illegal_exc, .o_bank_exc, .i_reg_addr,
    .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_irq);
  efd_regfile_model efd_regfile_model_inst (.i_clk, .i_rst, .i_base_bank(o_base_bank),
    .i_base_select(o_base_select), .i_index_bank(o_index_bank), .i_index_select(o_index_select),
    .o_base_data(i_base_data), .o_index_data(i_index_data));

  always #2 i_clk = ~i_clk;

  function automatic logic [31:0] sx(input logic [31:0] d, input int k);
    sx = k == 0 ? 32'h0000_0000 : k == 1 ? {{24{d[7]}}, d[7:0]} : k == 2 ? {{16{d[15]}}, d[15:0]} : d;
  endfunction

  function automatic logic [31:0] rv(input logic [3:0] b, input logic [3:0] s, input logic [15:0] lo);
    rv = {4'h0, b, 4'h0, s, lo};
  endfunction

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic send(input logic [7:0] b);
    int k;
    k = 0;
    i_byte_valid <= 1'b1;
    i_byte <= b;
    @(negedge i_clk);
    while (o_byte_ready !== 1'b1 && k < 20) begin
      @(negedge i_clk);
      k++;
    end
    @(posedge i_clk);
  endtask

  task automatic send_n(input logic [31:0] d, input int k);
    for (int j = k - 1; j >= 0; j--) begin
      send(d[8*j +: 8]);
    end
  endtask

  task automatic finish(input logic ed, input logic ei, input logic eb);
    sd = 1'b0;
    si = 1'b0;
    sb = 1'b0;
    sse = 1'b0;
    i_byte_valid <= 1'b0;
    i_byte <= ~i_byte;
    repeat (8) begin
      @(negedge i_clk);
      sd |= o_done === 1'b1;
      si |= o_illegal_exc === 1'b1;
      sb |= o_bank_exc === 1'b1;
      sse |= o_side_effect_en === 1'b1;
    end
    `CHK("done", ed, sd)
    `CHK("illegal", ei, si)
    `CHK("bank_exc", eb, sb)
    `CHK("side_on_fault", 1'b0, sse & (si | sb))
    @(posedge i_clk);
  endtask

  task automatic res(input efd_mode_t md, input logic [31:0] ea, input logic [3:0] eb);
    `CHK("mode", md, o_mode)
    `CHK("address", ea, o_effective_address)
    `CHK("exp_bytes", eb, o_exp_bytes)
  endtask

  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
    i_reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [1:0] a, input logic [31:0] e, input string nm);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    @(negedge i_clk);
    `CHK(nm, e, o_reg_rdata)
    @(posedge i_clk);
  endtask

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      stop_test();
    end
  end

  initial begin
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_clk);
    for (int s = 0; s < 4; s++) begin
      n = s == 3 ? 4 : s;
      send({2'b00, 2'(s), 4'h4});
      send_n(DV, n);
      finish(1'b1, 1'b0, 1'b0);
      res(MODE_REG_IND, rv(4'h9, 4'h4, 16'h7A3C) + sx(DV, n), 4'(n));
      `CHK("base_bank", 4'h9, o_base_bank)
    end
    // Scale, immediate, PC-relative, indexed, double indirect, fault and bank exception forms
    send(8'h79);
    send(8'h23);
    send(8'h81);
    finish(1'b1, 1'b0, 1'b0);
    res(MODE_SCALE, (rv(4'h9, 4'h3, 16'h7A3C) << 2) + 32'hFFFF_FF81, 4'h2);
    `CHK("base_select", 4'h3, o_base_select)
    send(8'h72);
    send_n(DV, 2);
    finish(1'b1, 1'b0, 1'b0);
    res(MODE_IMM, sx(DV, 2), 4'h2);
    send(8'h7D);
    send(8'h90);
    send(8'h81);
    finish(1'b1, 1'b0, 1'b0);
    res(MODE_PC_REL, i_pc + 32'hFFFF_FF81, 4'h2);
    i_two_operand <= 1'b1;
    send(8'hF0);
    send_n(32'h7D50_2381, 4);
    finish(1'b1, 1'b0, 1'b0);
    res(MODE_PC_INDEX, i_pc + 32'hFFFF_FF81 + (rv(4'h6, 4'h3, 16'h8F11) << 2), 4'h3);
    `CHK("index_bank", 4'h6, o_index_bank)
    `CHK("acc_dest", 1'b1, o_acc_dest)
    `CHK("expect_dest", 1'b0, o_expect_dest)
    i_current_bank_number <= 4'h0;
    send(8'h70);
    send_n(32'h0074_7C05, 3);
    send(8'h12);
    finish(1'b1, 1'b0, 1'b0);
    res(MODE_REG_INDEX, rv(4'hF, 4'h5, 16'h7A3C) + 32'hFFFF_1E22, 4'h2);
    `CHK("base_bank", 4'hF, o_base_bank)
    `CHK("index_bank", 4'h9, o_index_bank)
    `CHK("index_select", 4'h2, o_index_select)
    `CHK("expect_dest", 1'b1, o_expect_dest)
    i_two_operand <= 1'b0;
    for (int s2 = 0; s2 < 4; s2++) begin
      for (int s1 = 0; s1 < 4; s1++) begin
        send(8'h7E);
        send({2'(s2), 2'(s1), 4'h7});
        if (s2 % 2 == 1 && s1 % 2 == 1) begin
          n = s2 == 3 ? 4 : 1;
          m = s1 == 3 ? 4 : 1;
          send_n(DV, n);
          send_n(DW, m);
          finish(1'b1, 1'b0, 1'b0);
          res(MODE_DOUBLE, rv(4'h9, 4'h7, 16'h7A3C) + sx(DV, n), 4'(1 + n + m));
          `CHK("outer", sx(DW, m), o_outer_displacement)
        end else begin
          finish(1'b0, 1'b1, 1'b0);
        end
      end
    end
    send(8'h7F);
    finish(1'b0, 1'b1, 1'b0);
    send(8'h7C);
    send(8'h80);
    finish(1'b0, 1'b1, 1'b0);
    send(8'h7D);
    send(8'hC0);
    finish(1'b0, 1'b1, 1'b0);
    i_ring_mode <= 1'b0;
    send(8'h70);
    finish(1'b0, 1'b0, 1'b1);
    send(8'h74);
    finish(1'b0, 1'b0, 1'b1);
    send(8'h5A);
    finish(1'b1, 1'b0, 1'b0);
    `CHK("side_effect", 1'b1, sse)
    `CHK("mode", MODE_AUTO_INC, o_mode)
    i_ring_mode <= 1'b1;
    // Status, mask and interrupt
    rd(REG_STATUS, 32'h0000_0007, "status");
    rd(REG_STATUS, 32'h0000_0000, "status_clear");
    rd(REG_MASK, 32'h0000_0000, "mask_reset");
    wr(REG_STATUS, 32'h0000_0007);
    rd(REG_STATUS, 32'h0000_0000, "status_ro");
    wr(REG_MASK, 32'hFFFF_FFF9);
    rd(REG_MASK, 32'h0000_0001, "mask");
    rd(2'h3, 32'h0000_0000, "unmapped");
    send(8'h7F);
    finish(1'b0, 1'b1, 1'b0);
    `CHK("irq_set", 1'b1, o_irq)
    rd(REG_STATUS, 32'h0000_0001, "status_illegal");
    send(8'h04);
    finish(1'b1, 1'b0, 1'b0);
    `CHK("irq_masked", 1'b0, o_irq)
    stop_test();
  end
endmodule
